// file: ring_gp_consts.vh
// constants for the ring resiliency and general purpose register bank
// Notes on behaviour
// - page value 0x0010 selects general purpose page
// - page value 0x0000 returns to main page
// - general purpose bits survive software resets
// - ring bit 15 sticky startup enable, reset 0
// - bit 14 local advert, bit 13 partner advert
// - bit 12 forces ring resiliency on
// - bits 5:4 report timing role, reset 00
// - first link-up loads role from autoneg
// - bit 0 starts switchover, then self-clears
// - aux clock bit 15 enables output pin
// - bits 14:13 select aux clock frequency
// - gpio bit 13 active-low pin output enable
// - gpio bit 12 holds pin output value
// - gpio bit 11 reads pin level
// - gpio bit 9 tri-states led outputs
// - alert bits 3:0, 0000 on, 1111 off
`ifndef RING_GP_CONSTS_VH
`define RING_GP_CONSTS_VH

// register indices, byte address is four times the index
`define IDX_AUX_CLOCK 5'h0d
`define IDX_GPIO_TWO 5'h0e
`define IDX_LINK_ALERT 5'h13
`define IDX_TIMING_ROLE 5'h1e
`define IDX_PAGE_SELECT 5'h1f

// page select values
`define PAGE_MAIN 16'h0000
`define PAGE_EXT_TWO 16'h0002
`define PAGE_GP 16'h0010

// decoded register selections
`define SEL_NONE 3'h0
`define SEL_PAGE 3'h1
`define SEL_AUX 3'h2
`define SEL_GPIO 3'h3
`define SEL_ALERT 3'h4
`define SEL_ROLE 3'h5
`define SEL_ERROR 3'h6

// timing role register fields
`define ROLE_STARTUP_BIT 15
`define ROLE_ADV_BIT 14
`define ROLE_LP_ADV_BIT 13
`define ROLE_FORCE_BIT 12
`define ROLE_STATUS_HI 5
`define ROLE_STATUS_LO 4
`define ROLE_SWITCH_BIT 0

// timing role codes
`define ROLE_SLAVE 2'h0
`define ROLE_M2S 2'h1
`define ROLE_S2M 2'h2
`define ROLE_MASTER 2'h3

// aux clock fields
`define AUX_EN_BIT 15
`define AUX_FREQ_HI 14
`define AUX_FREQ_LO 13
`define AUX_EN_RESET 1'b0
`define AUX_FREQ_RESET 2'h0

// gpio fields
`define GPIO_OE_N_BIT 13
`define GPIO_OUT_BIT 12
`define GPIO_IN_BIT 11
`define GPIO_LED_TRI_BIT 9
`define GPIO_OE_N_RESET 1'b1
`define GPIO_OUT_RESET 1'b0
`define GPIO_LED_TRI_RESET 1'b1

// link drop alert field
`define ALERT_ENABLED 4'h0
`define ALERT_DISABLED 4'hf
`define ALERT_RESET 4'h0

`endif

// file: timing_role_tracker.v
// timing master/slave role state and switchover sequencing
`timescale 1ns/1ps
`include "ring_gp_consts.vh"
module timing_role_tracker (
    input wire pclk,
    input wire presetn,
    input wire soft_reset,
    input wire link_up,
    input wire an_master,
    input wire start_req,
    input wire switch_done,
    output reg [1:0] status,
    output wire busy,
    output reg switch_start
);
    reg link_seen;
    reg [1:0] next_status;

    assign busy = (status == `ROLE_S2M) || (status == `ROLE_M2S);

    ////////////////////////////////////////////////////////////////////////
    // role sequencing
    always @* begin
        next_status = status;
        case (status)
            `ROLE_SLAVE: begin
                if (link_up && !link_seen) begin
                    next_status = an_master ? `ROLE_MASTER : `ROLE_SLAVE;
                end else if (start_req) begin
                    next_status = `ROLE_S2M;
                end
            end
            `ROLE_MASTER: begin
                if (link_up && !link_seen) begin
                    next_status = an_master ? `ROLE_MASTER : `ROLE_SLAVE;
                end else if (start_req) begin
                    next_status = `ROLE_M2S;
                end
            end
            `ROLE_S2M: begin
                if (switch_done) begin
                    next_status = `ROLE_MASTER;
                end
            end
            default: begin
                if (switch_done) begin
                    next_status = `ROLE_SLAVE;
                end
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= `ROLE_SLAVE;
            link_seen <= 1'b0;
            switch_start <= 1'b0;
        end else if (soft_reset) begin
            status <= `ROLE_SLAVE;
            link_seen <= 1'b0;
            switch_start <= 1'b0;
        end else begin
            status <= next_status;
            if (link_up) begin
                link_seen <= 1'b1;
            end
            switch_start <= start_req && !busy && !(link_up && !link_seen);
        end
    end
endmodule

// file: ring_resiliency_gp_regs.v
// apb register bank for ring resiliency and general purpose page controls
`timescale 1ns/1ps
`include "ring_gp_consts.vh"
module ring_resiliency_gp_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire soft_reset,
    input wire link_up,
    input wire an_master,
    input wire lp_rr_adv,
    input wire switch_done,
    input wire low_power_hold_pin_in,
    output wire low_power_hold_pin_out,
    output wire low_power_hold_pin_oe,
    output wire aux_clock_output_en,
    output wire [1:0] aux_clock_output_freq,
    output wire led_tristate,
    output wire link_drop_alert_pin_en,
    output wire [3:0] link_drop_alert_setting,
    output wire rr_startup_enable,
    output wire rr_advertise,
    output wire rr_force,
    output wire rr_active,
    output wire switch_start
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function [2:0] decode_sel;
        input [7:0] addr;
        input [15:0] page;
        reg [4:0] idx;
        begin
            idx = addr[6:2];
            if (addr[7] || (addr[1:0] != 2'h0)) begin
                decode_sel = `SEL_ERROR;
            end else if (idx == `IDX_PAGE_SELECT) begin
                decode_sel = `SEL_PAGE;
            end else if (page == `PAGE_GP && idx == `IDX_AUX_CLOCK) begin
                decode_sel = `SEL_AUX;
            end else if (page == `PAGE_GP && idx == `IDX_GPIO_TWO) begin
                decode_sel = `SEL_GPIO;
            end else if (page == `PAGE_GP && idx == `IDX_LINK_ALERT) begin
                decode_sel = `SEL_ALERT;
            end else if (page == `PAGE_EXT_TWO && idx == `IDX_TIMING_ROLE) begin
                decode_sel = `SEL_ROLE;
            end else begin
                decode_sel = `SEL_NONE;
            end
        end
    endfunction

    // merge byte lanes of write data over the old value
    function [15:0] lane_merge;
        input [15:0] old;
        input [15:0] wdata;
        input [1:0] strb;
        begin
            lane_merge[7:0] = strb[0] ? wdata[7:0] : old[7:0];
            lane_merge[15:8] = strb[1] ? wdata[15:8] : old[15:8];
        end
    endfunction

    // read views of each register, reserved bits zero
    function [15:0] aux_view;
        input en;
        input [1:0] freq;
        begin
            aux_view = 16'h0000;
            aux_view[`AUX_EN_BIT] = en;
            aux_view[`AUX_FREQ_HI:`AUX_FREQ_LO] = freq;
        end
    endfunction

    function [15:0] gpio_view;
        input oe_n;
        input out;
        input pin;
        input led_off;
        begin
            gpio_view = 16'h0000;
            gpio_view[`GPIO_OE_N_BIT] = oe_n;
            gpio_view[`GPIO_OUT_BIT] = out;
            gpio_view[`GPIO_IN_BIT] = pin;
            gpio_view[`GPIO_LED_TRI_BIT] = led_off;
        end
    endfunction

    function [15:0] alert_view;
        input [3:0] setting;
        begin
            alert_view = {12'h000, setting};
        end
    endfunction

    function [15:0] role_view;
        input startup;
        input adv;
        input lp_adv;
        input forced;
        input [1:0] role;
        input busy;
        begin
            role_view = 16'h0000;
            role_view[`ROLE_STARTUP_BIT] = startup;
            role_view[`ROLE_ADV_BIT] = adv;
            role_view[`ROLE_LP_ADV_BIT] = lp_adv;
            role_view[`ROLE_FORCE_BIT] = forced;
            role_view[`ROLE_STATUS_HI:`ROLE_STATUS_LO] = role;
            role_view[`ROLE_SWITCH_BIT] = busy;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    reg [15:0] page_select;
    reg aux_en;
    reg [1:0] aux_freq;
    reg gpio_oe_n;
    reg gpio_out;
    reg led_tri;
    reg [3:0] alert_setting;
    reg role_startup;
    reg role_adv;
    reg role_force;

    wire [2:0] sel;
    wire setup_phase;
    wire write_access;
    wire [15:0] wmerge;
    wire [1:0] role_status;
    wire role_busy;
    wire start_req;
    reg [15:0] read_word;
    reg [15:0] next_page_select;
    reg next_aux_en;
    reg [1:0] next_aux_freq;
    reg next_gpio_oe_n;
    reg next_gpio_out;
    reg next_led_tri;
    reg [3:0] next_alert_setting;
    reg next_role_startup;
    reg next_role_adv;
    reg next_role_force;
    wire wr_page;
    wire wr_aux;
    wire wr_gpio;
    wire wr_alert;
    wire wr_role;
    wire switch_write;

    assign sel = decode_sel(paddr, page_select);
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite && (sel != `SEL_ERROR);
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // write strobes, one per register
    assign wr_page = write_access && (sel == `SEL_PAGE);
    assign wr_aux = write_access && (sel == `SEL_AUX);
    assign wr_gpio = write_access && (sel == `SEL_GPIO);
    assign wr_alert = write_access && (sel == `SEL_ALERT);
    assign wr_role = write_access && (sel == `SEL_ROLE);

    ////////////////////////////////////////////////////////////////////////
    // page select, cleared by software reset of the phy

    always @* begin
        next_page_select = page_select;
        if (wr_page) begin
            next_page_select = lane_merge(page_select, pwdata[15:0], pstrb[1:0]);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_select <= `PAGE_MAIN;
        end else if (soft_reset) begin
            page_select <= `PAGE_MAIN;
        end else begin
            page_select <= next_page_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general purpose page, untouched by software reset

    assign wmerge = lane_merge(read_word, pwdata[15:0], pstrb[1:0]);

    always @* begin
        next_aux_en = aux_en;
        next_aux_freq = aux_freq;
        next_gpio_oe_n = gpio_oe_n;
        next_gpio_out = gpio_out;
        next_led_tri = led_tri;
        next_alert_setting = alert_setting;
        if (wr_aux) begin
            next_aux_en = wmerge[`AUX_EN_BIT];
            next_aux_freq = wmerge[`AUX_FREQ_HI:`AUX_FREQ_LO];
        end
        if (wr_gpio) begin
            next_gpio_oe_n = wmerge[`GPIO_OE_N_BIT];
            next_gpio_out = wmerge[`GPIO_OUT_BIT];
            next_led_tri = wmerge[`GPIO_LED_TRI_BIT];
        end
        if (wr_alert) begin
            next_alert_setting = wmerge[3:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_en <= `AUX_EN_RESET;
            aux_freq <= `AUX_FREQ_RESET;
        end else begin
            aux_en <= next_aux_en;
            aux_freq <= next_aux_freq;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_oe_n <= `GPIO_OE_N_RESET;
            gpio_out <= `GPIO_OUT_RESET;
            led_tri <= `GPIO_LED_TRI_RESET;
        end else begin
            gpio_oe_n <= next_gpio_oe_n;
            gpio_out <= next_gpio_out;
            led_tri <= next_led_tri;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_setting <= `ALERT_RESET;
        end else begin
            alert_setting <= next_alert_setting;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timing role sticky controls

    always @* begin
        next_role_startup = role_startup;
        next_role_adv = role_adv;
        next_role_force = role_force;
        if (wr_role) begin
            next_role_startup = wmerge[`ROLE_STARTUP_BIT];
            next_role_adv = wmerge[`ROLE_ADV_BIT];
            next_role_force = wmerge[`ROLE_FORCE_BIT];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            role_startup <= 1'b0;
            role_adv <= 1'b0;
            role_force <= 1'b0;
        end else begin
            role_startup <= next_role_startup;
            role_adv <= next_role_adv;
            role_force <= next_role_force;
        end
    end

    // switchover request, honoured only when idle and feature active
    assign switch_write = wr_role && pstrb[0] && pwdata[`ROLE_SWITCH_BIT];
    assign start_req = switch_write && !role_busy && rr_active;

    timing_role_tracker u_tracker (
        .pclk(pclk),
        .presetn(presetn),
        .soft_reset(soft_reset),
        .link_up(link_up),
        .an_master(an_master),
        .start_req(start_req),
        .switch_done(switch_done),
        .status(role_status),
        .busy(role_busy),
        .switch_start(switch_start)
    );

    ////////////////////////////////////////////////////////////////////////
    // read mux

    always @* begin
        read_word = 16'h0000;
        if (sel == `SEL_PAGE) begin
            read_word = page_select;
        end else if (sel == `SEL_AUX) begin
            read_word = aux_view(aux_en, aux_freq);
        end else if (sel == `SEL_GPIO) begin
            read_word = gpio_view(gpio_oe_n, gpio_out, low_power_hold_pin_in, led_tri);
        end else if (sel == `SEL_ALERT) begin
            read_word = alert_view(alert_setting);
        end else if (sel == `SEL_ROLE) begin
            read_word = role_view(role_startup, role_adv, lp_rr_adv, role_force, role_status,
                role_busy);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer registers, loaded in the setup cycle

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : {16'h0000, read_word};
            pslverr <= (sel == `SEL_ERROR);
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin and control outputs

    assign aux_clock_output_en = aux_en;
    assign aux_clock_output_freq = aux_freq;
    assign low_power_hold_pin_oe = !gpio_oe_n;
    assign low_power_hold_pin_out = gpio_out;
    assign led_tristate = led_tri;
    assign link_drop_alert_setting = alert_setting;
    assign link_drop_alert_pin_en = (alert_setting == `ALERT_ENABLED);
    assign rr_startup_enable = role_startup;
    assign rr_advertise = role_adv;
    assign rr_force = role_force;
    assign rr_active = role_force || (role_adv && lp_rr_adv);

endmodule

// file: ring_gp_regs_sva.sv
// assertion checker for the ring resiliency and general purpose register bank
`timescale 1ns/1ps
module ring_gp_regs_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire lp_rr_adv,
    input wire low_power_hold_pin_oe,
    input wire aux_clock_output_en,
    input wire [1:0] aux_clock_output_freq,
    input wire led_tristate,
    input wire link_drop_alert_pin_en,
    input wire [3:0] link_drop_alert_setting,
    input wire rr_startup_enable,
    input wire rr_advertise,
    input wire rr_force,
    input wire rr_active,
    input wire switch_start
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    a_alert_pin_en: assert property (link_drop_alert_pin_en == (link_drop_alert_setting == 4'h0))
        else $error("alert pin enable does not follow setting");
    a_active_mix: assert property (rr_active == (rr_force | (rr_advertise & lp_rr_adv)))
        else $error("ring resiliency active wrong");
    a_start_pulse: assert property (switch_start |=> !switch_start)
        else $error("switchover start longer than one cycle");
    a_start_cause: assert property (switch_start |-> $past(pwrite & penable) || $past(pwrite & penable, 2))
        else $error("switchover start without write");
    a_reset_vals: assert property ($rose(presetn) |-> !aux_clock_output_en && led_tristate
        && !low_power_hold_pin_oe && link_drop_alert_pin_en)
        else $error("reset values wrong");
    a_regs_hold: assert property (!(psel && penable && pwrite) |=> $stable({aux_clock_output_en,
        aux_clock_output_freq, led_tristate, low_power_hold_pin_oe, link_drop_alert_setting,
        rr_startup_enable, rr_advertise, rr_force}))
        else $error("control changed without write");
    a_upper_zero: assert property (psel && penable |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_err_resp: assert property (psel && !penable && paddr[7] |=> pslverr && prdata == 32'h0000_0000)
        else $error("no error for bad address");
    a_no_err: assert property (psel && !penable && !paddr[7] && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on aligned address");
endmodule
bind ring_resiliency_gp_regs ring_gp_regs_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .lp_rr_adv(lp_rr_adv), .low_power_hold_pin_oe(low_power_hold_pin_oe),
    .aux_clock_output_en(aux_clock_output_en), .aux_clock_output_freq(aux_clock_output_freq),
    .led_tristate(led_tristate), .link_drop_alert_pin_en(link_drop_alert_pin_en),
    .link_drop_alert_setting(link_drop_alert_setting), .rr_startup_enable(rr_startup_enable),
    .rr_advertise(rr_advertise), .rr_force(rr_force), .rr_active(rr_active),
    .switch_start(switch_start));

// file: ring_resiliency_gp_regs_test.sv
// self-checking bench for the ring resiliency and general purpose register bank
`timescale 1ns/1ps
`include "ring_gp_consts.vh"
module ring_resiliency_gp_regs_test;
    logic pclk, presetn, psel, penable, pwrite, soft_reset, link_up, an_master, lp_rr_adv;
    logic switch_done, pin_in, err_seen;
    logic seen_start = 1'b0;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0] pstrb;
    logic [15:0] last [0:2];
    logic [4:0] idx [0:2];
    logic [15:0] mask [0:2];
    integer errors, compares, seed, i, k;
    wire [31:0] prdata;
    wire pready, pslverr, pin_out, pin_oe, aux_en, led_tri, alert_en, sw_start;
    wire rr_start_en, rr_adv, rr_frc, rr_act;
    wire [1:0] aux_freq;
    wire [3:0] alert_set;
    ring_resiliency_gp_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset),
        .link_up(link_up), .an_master(an_master), .lp_rr_adv(lp_rr_adv),
        .switch_done(switch_done), .low_power_hold_pin_in(pin_in),
        .low_power_hold_pin_out(pin_out), .low_power_hold_pin_oe(pin_oe),
        .aux_clock_output_en(aux_en), .aux_clock_output_freq(aux_freq),
        .led_tristate(led_tri), .link_drop_alert_pin_en(alert_en),
        .link_drop_alert_setting(alert_set), .rr_startup_enable(rr_start_en),
        .rr_advertise(rr_adv), .rr_force(rr_frc), .rr_active(rr_act),
        .switch_start(sw_start));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (sw_start === 1'b1) seen_start <= 1'b1;
    end
    function logic [7:0] ad(input logic [4:0] x);
        ad = {1'b0, x, 2'b00};
    endfunction
    function logic [31:0] exp_gp(input integer n, input logic [15:0] d, input logic p);
        exp_gp = {16'h0000, d & mask[n]};
        if (n == 1) exp_gp[11] = p;
    endfunction
    function logic [31:0] exp_pins;
        exp_pins = {21'h0_0000, last[0][15:13], ~last[1][13], last[1][12], last[1][9],
            last[2][3:0] == 4'h0, last[2][3:0]};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one apb transfer, leaves one idle edge after it
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        integer n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (pready !== 1'b1) begin
            errors = errors + 1;
            wrap_up;
        end
    endtask
    // one-cycle strobe: switch_done when done is set, soft_reset otherwise
    task pulse(input logic done);
        if (done) switch_done <= 1'b1;
        else soft_reset <= 1'b1;
        @(posedge pclk);
        switch_done <= 1'b0;
        soft_reset <= 1'b0;
        @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 18;
        errors = 0;
        compares = 0;
        {presetn, psel, penable, pwrite, soft_reset, link_up, an_master} = 7'h00;
        {lp_rr_adv, switch_done, pin_in} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        idx = '{`IDX_AUX_CLOCK, `IDX_GPIO_TWO, `IDX_LINK_ALERT};
        mask = '{16'he000, 16'h3200, 16'h000f};
        last = '{16'h0000, 16'h2200, 16'h0000};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ad(`IDX_AUX_CLOCK), 16'h0000);
        chk(rd, 32'h0000_0000);
        apb(1, ad(`IDX_PAGE_SELECT), `PAGE_GP);
        apb(0, ad(`IDX_PAGE_SELECT), 16'h0000);
        chk(rd, 32'h0000_0010);
        for (i = 0; i < 27; i++) begin
            k = i % 3;
            if (i >= 3) begin
                pin_in <= 1'($random(seed));
                last[k] = 16'($random(seed));
                apb(1, ad(idx[k]), last[k]);
            end
            apb(0, ad(idx[k]), 16'h0000);
            chk(rd, exp_gp(k, last[k], pin_in));
            chk({21'h0_0000, aux_en, aux_freq, pin_oe, pin_out, led_tri, alert_en, alert_set},
                exp_pins());
        end
        pulse(1'b0);
        apb(0, ad(`IDX_PAGE_SELECT), 16'h0000);
        chk(rd, 32'h0000_0000);
        apb(1, ad(`IDX_PAGE_SELECT), `PAGE_GP);
        for (k = 0; k < 3; k++) begin
            apb(0, ad(idx[k]), 16'h0000);
            chk(rd, exp_gp(k, last[k], pin_in));
        end
        pstrb <= 4'h2;
        apb(1, ad(`IDX_LINK_ALERT), 16'h000f);
        pstrb <= 4'hf;
        apb(0, ad(`IDX_LINK_ALERT), 16'h0000);
        chk(rd, exp_gp(2, last[2], pin_in));
        apb(0, ad(5'h10), 16'h0000);
        chk({rd[30:0], err_seen}, 32'h0000_0000);
        apb(1, ad(`IDX_PAGE_SELECT), `PAGE_EXT_TWO);
        apb(1, ad(`IDX_TIMING_ROLE), 16'hf000);
        apb(0, ad(`IDX_TIMING_ROLE), 16'h0000);
        chk(rd, 32'h0000_d000);
        chk({28'h000_0000, rr_start_en, rr_adv, rr_frc, rr_act}, 32'h0000_000f);
        lp_rr_adv <= 1'b1;
        link_up <= 1'b1;
        an_master <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, ad(`IDX_TIMING_ROLE), 16'h0000);
        chk(rd, 32'h0000_f030);
        apb(1, ad(`IDX_TIMING_ROLE), 16'hd001);
        apb(0, ad(`IDX_TIMING_ROLE), 16'h0000);
        chk(rd, 32'h0000_f011);
        chk(32'(seen_start), 32'h0000_0001);
        pulse(1'b1);
        apb(0, ad(`IDX_TIMING_ROLE), 16'h0000);
        chk(rd, 32'h0000_f000);
        apb(0, 8'h80, 16'h0000);
        chk(32'(err_seen), 32'h0000_0001);
        apb(1, 8'h35, 16'hffff);
        chk(32'(err_seen), 32'h0000_0001);
        apb(1, ad(`IDX_PAGE_SELECT), `PAGE_MAIN);
        apb(0, ad(`IDX_TIMING_ROLE), 16'h0000);
        chk(rd, 32'h0000_0000);
        wrap_up;
    end
endmodule
